// ===== design/sel_pkg.sv
/*
 Package for the serial EEPROM command controller and loader.
 Assumes a 100 MHz ref_clk and a three-wire serial EEPROM on the far side.
*/
package sel_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TIMEOUT_MS = 30;
  localparam int unsigned TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int unsigned SK_HALF_NS = 500;
  localparam int unsigned SK_HALF_CYC = (SK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Ready polls ignored until the line sampled under chip select has cleared the synchroniser
  localparam int unsigned RDY_SETTLE_CYC = 2;

  localparam logic [1:0] SIZE_7 = 2'h0;
  localparam logic [1:0] SIZE_9 = 2'h1;
  localparam logic [1:0] SIZE_11 = 2'h2;
  localparam logic [3:0] ABITS_7 = 4'h7;
  localparam logic [3:0] ABITS_9 = 4'h9;
  localparam logic [3:0] ABITS_11 = 4'hb;
  localparam logic [3:0] HDR_BITS = 4'h3;
  localparam logic [3:0] DATA_BITS = 4'h8;

  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] EXT_BULK_ERASE = 2'h2;
  localparam logic [1:0] EXT_WR_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WR_ENABLE = 2'h3;
  localparam logic [1:0] EXT_FILL_ALL = 2'h1;

  localparam logic [7:0] VALID_FLAG = 8'ha5;
  localparam logic [3:0] LB_FLAG = 4'h0;
  localparam logic [3:0] LB_MAC_LAST = 4'h6;
  localparam logic [3:0] LB_STRAP_FLAG = 4'h7;
  localparam logic [3:0] LB_STRAP_LAST = 4'hb;
  localparam logic [3:0] LB_BURST_FLAG = 4'hc;
  localparam logic [3:0] LB_BURST_CNT = 4'hd;
  localparam logic [11:0] REG_MIN_OFS = 12'h100;
  localparam logic [11:0] PHY_DATA_OFS = 12'h0a4;
  localparam logic [11:0] PHY_ACCESS_OFS = 12'h0a8;

  typedef enum logic [2:0] {
    SEL_CMD_READ, SEL_CMD_WRITE, SEL_CMD_ERASE, SEL_CMD_BULK_ERASE,
    SEL_CMD_WR_DISABLE, SEL_CMD_WR_ENABLE, SEL_CMD_FILL_ALL, SEL_CMD_RELOAD
  } sel_cmd_t;

  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } sel_pins_t;

  typedef struct packed {
    logic [47:0] mac;
    logic [31:0] straps;
    logic strap_valid;
    logic [7:0] burst_cnt;
    logic burst_valid;
  } sel_load_t;
endpackage

// ===== design/sel_loader.sv
/*
 Serial EEPROM command controller with the reset-time content loader.
 Assumes the EEPROM data output and its ready/busy level arrive asynchronously
 on eep_do; the register writes the loader issues are taken by the system fabric.
*/
// Functional notes
// - Size strap picks 7, 9 or 11 address bits; code 11 reserved.
// - For read, write and erase, every address bit of the chosen width is shifted as supplied.
// - Start bit 1 then opcode: read 10, write 01, erase 11, extended 00.
// - Extended commands coded by two top address bits.
// - No-data commands take 10/12/14 clocks; data commands 18/20/22.
// - Read fetches eight bits MSB first into the data register.
// - Write shifts the data register byte after the address.
// - Erase sends the command location for a single-location erase.
// - Bulk erase clears the whole array when enabled in the EEPROM.
// - Fill-all sends the data byte for every location.
// - After erase/write commands wait for ready; 30 ms sets timeout flag.
// - Loader starts on pin, power-on, digital reset or reload command.
// - Soft-reset loads only the MAC address.
// - Loader writes only offsets 100h and up, plus A4 and A8.
// - Byte 0 must be A5h; bytes 1-6 are the MAC address.
// - Byte 7 strap flag, 8-11 straps, 12 burst flag, 13 count.
// - Bad first byte: sync PHY from current straps, stop, clear busy; after a soft reset the loader stops without the PHY sync.
// - Busy set, config and power ready cleared while loading.
// - Bad strap flag: bytes 8-11 still read but discarded.
`timescale 1ns/1ps
`default_nettype none
module sel_loader
  import sel_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_reset_n,
  input wire logic por_event,
  input wire logic digital_reset,
  input wire logic soft_reset,
  input wire logic [1:0] size_strap,
  input wire logic cmd_go,
  input wire sel_cmd_t cmd_sel,
  input wire logic [10:0] cmd_location_field,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic eep_do,
  output sel_pins_t eep_pins,
  output logic [7:0] nvm_data_reg,
  output logic nvm_busy_flag,
  output logic nvm_response_timeout_flag,
  output logic config_ready,
  output logic power_ready,
  output sel_load_t load_out,
  output logic load_done,
  output logic phy_sync,
  output logic reg_wr_en,
  output logic [11:0] reg_wr_addr
);
  typedef enum {S_IDLE, S_SHIFT, S_GAP, S_WAIT, S_LOAD} sel_state_t;

  sel_state_t state_reg;
  logic [21:0] sreg_reg;
  logic [4:0] bit_cnt_reg;
  logic [4:0] total_reg;
  logic [7:0] rx_reg;
  logic [7:0] tmr_reg;
  logic [31:0] to_cnt_reg;
  logic is_read_reg, wait_rdy_reg;
  logic loading_reg, soft_reg;
  logic [3:0] lb_reg;
  logic [1:0] do_sync_reg, prst_sync_reg;
  logic pin_rst_seen_reg;
  logic start_load;
  logic [3:0] abits;
  logic [1:0] op;
  logic [1:0] ext;
  logic [10:0] addr_field;
  logic has_data;
  logic [7:0] rx_byte;

  // Synchronise the EEPROM data/ready line and the reset pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      do_sync_reg <= 2'h0;
      prst_sync_reg <= 2'h3;
    end else begin
      do_sync_reg <= {do_sync_reg[0], eep_do};
      prst_sync_reg <= {prst_sync_reg[0], pin_reset_n};
    end
  end

  // Pin reset counts on its release edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_rst_seen_reg <= 1'b0;
    end else begin
      pin_rst_seen_reg <= !prst_sync_reg[1];
    end
  end

  assign start_load = (pin_rst_seen_reg && prst_sync_reg[1]) || por_event || digital_reset
    || soft_reset || (cmd_go && cmd_sel == SEL_CMD_RELOAD);

  always_comb begin
    case (size_strap)
      SIZE_7: abits = ABITS_7;
      SIZE_9: abits = ABITS_9;
      SIZE_11: abits = ABITS_11;
      default: abits = ABITS_11;
    endcase
  end

  always_comb begin
    op = OP_EXT;
    ext = EXT_WR_DISABLE;
    has_data = 1'b0;
    case (cmd_sel)
      SEL_CMD_READ: begin
        op = OP_READ;
        has_data = 1'b1;
      end
      SEL_CMD_WRITE: begin
        op = OP_WRITE;
        has_data = 1'b1;
      end
      SEL_CMD_ERASE: op = OP_ERASE;
      SEL_CMD_BULK_ERASE: ext = EXT_BULK_ERASE;
      SEL_CMD_WR_ENABLE: ext = EXT_WR_ENABLE;
      SEL_CMD_FILL_ALL: begin
        ext = EXT_FILL_ALL;
        has_data = 1'b1;
      end
      default: ext = EXT_WR_DISABLE;
    endcase
  end

  // Extended code sits in the two top bits of the selected width
  always_comb begin
    addr_field = cmd_location_field;
    if (op == OP_EXT) begin
      addr_field = 11'({ext, 9'h000} >> (ABITS_11 - abits));
    end
  end

  assign rx_byte = {rx_reg[6:0], do_sync_reg[1]};

  // Command sequencer and serial engine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      sreg_reg <= '0;
      bit_cnt_reg <= '0;
      total_reg <= '0;
      rx_reg <= '0;
      tmr_reg <= '0;
      to_cnt_reg <= '0;
      is_read_reg <= 1'b0;
      wait_rdy_reg <= 1'b0;
      eep_pins <= '0;
      nvm_response_timeout_flag <= 1'b0;
      loading_reg <= 1'b0;
      soft_reg <= 1'b0;
      lb_reg <= '0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          eep_pins <= '0;
          if (start_load) begin
            loading_reg <= 1'b1;
            soft_reg <= soft_reset;
            lb_reg <= LB_FLAG;
            state_reg <= S_LOAD;
          end else if (cmd_go) begin
            nvm_response_timeout_flag <= 1'b0;
            // Header fixed on top; address of the chosen width packed right under it
            sreg_reg <= {1'b1, op, 19'({addr_field, (cmd_sel == SEL_CMD_READ) ? 8'h00 :
              nvm_data_reg} << (5'(ABITS_11) - 5'(abits)))};
            total_reg <= 5'(HDR_BITS) + 5'(abits) + (has_data ? 5'(DATA_BITS) : 5'h00);
            is_read_reg <= (cmd_sel == SEL_CMD_READ);
            wait_rdy_reg <= (cmd_sel == SEL_CMD_WRITE) || (cmd_sel == SEL_CMD_ERASE)
              || (cmd_sel == SEL_CMD_BULK_ERASE) || (cmd_sel == SEL_CMD_FILL_ALL);
            bit_cnt_reg <= '0;
            tmr_reg <= '0;
            eep_pins <= '{cs: 1'b1, sk: 1'b0, di: 1'b0};
            state_reg <= S_SHIFT;
          end
        end
        S_LOAD: begin
          // Sequential read of one content byte per frame
          sreg_reg <= {1'b1, OP_READ, 19'({11'(lb_reg), 8'h00} << (5'(ABITS_11) - 5'(abits)))};
          total_reg <= 5'(HDR_BITS) + 5'(abits) + 5'(DATA_BITS);
          is_read_reg <= 1'b1;
          wait_rdy_reg <= 1'b0;
          bit_cnt_reg <= '0;
          tmr_reg <= '0;
          eep_pins <= '{cs: 1'b1, sk: 1'b0, di: 1'b0};
          state_reg <= S_SHIFT;
        end
        S_SHIFT: begin
          tmr_reg <= tmr_reg + 8'h01;
          if (tmr_reg == 8'(SK_HALF_CYC - 1)) begin
            eep_pins.di <= sreg_reg[21];
          end else if (tmr_reg == 8'(2 * SK_HALF_CYC - 1)) begin
            eep_pins.sk <= 1'b1;
          end else if (tmr_reg == 8'(3 * SK_HALF_CYC - 1)) begin
            eep_pins.sk <= 1'b0;
            tmr_reg <= 8'(SK_HALF_CYC);
            sreg_reg <= {sreg_reg[20:0], 1'b0};
            // Next bit changes on the falling clock, a full half period before sampling
            eep_pins.di <= sreg_reg[20];
            if (is_read_reg && bit_cnt_reg >= total_reg - 5'(DATA_BITS)) begin
              rx_reg <= rx_byte;
            end
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == total_reg - 5'h01) begin
              eep_pins <= '0;
              tmr_reg <= '0;
              state_reg <= S_GAP;
            end
          end
        end
        S_GAP: begin
          // Chip select low between frames, then raised again for ready polling
          tmr_reg <= tmr_reg + 8'h01;
          if (tmr_reg == 8'(2 * SK_HALF_CYC - 1)) begin
            to_cnt_reg <= '0;
            if (wait_rdy_reg) begin
              eep_pins.cs <= 1'b1;
              state_reg <= S_WAIT;
            end else if (loading_reg) begin
              lb_reg <= lb_reg + 4'h1;
              if ((lb_reg == LB_FLAG && rx_reg != VALID_FLAG)
                  || (soft_reg && lb_reg == LB_MAC_LAST)
                  || lb_reg == LB_BURST_CNT) begin
                loading_reg <= 1'b0;
                state_reg <= S_IDLE;
              end else begin
                state_reg <= S_LOAD;
              end
            end else begin
              state_reg <= S_IDLE;
            end
          end
        end
        S_WAIT: begin
          to_cnt_reg <= to_cnt_reg + 32'h1;
          if (do_sync_reg[1] && to_cnt_reg >= 32'(RDY_SETTLE_CYC)) begin
            eep_pins <= '0;
            state_reg <= S_IDLE;
          end else if (to_cnt_reg == 32'(TIMEOUT_CYCLES - 1)) begin
            nvm_response_timeout_flag <= 1'b1;
            eep_pins <= '0;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Data register: software write, or captured read byte
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nvm_data_reg <= '0;
    end else if (state_reg == S_GAP && tmr_reg == 8'h00 && is_read_reg) begin
      nvm_data_reg <= rx_reg;
    end else if (data_wr && state_reg == S_IDLE) begin
      nvm_data_reg <= data_wdata;
    end
  end

  // Busy and ready indications
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nvm_busy_flag <= 1'b1;
      config_ready <= 1'b0;
      power_ready <= 1'b0;
    end else begin
      nvm_busy_flag <= (state_reg != S_IDLE) || start_load || cmd_go;
      config_ready <= !(loading_reg || start_load);
      power_ready <= !(loading_reg || start_load);
    end
  end

  // Parsed content and loader register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      load_out <= '0;
      load_done <= 1'b0;
      phy_sync <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_wr_addr <= REG_MIN_OFS;
    end else begin
      load_done <= 1'b0;
      phy_sync <= 1'b0;
      reg_wr_en <= 1'b0;
      if (loading_reg && state_reg == S_GAP && tmr_reg == 8'h01) begin
        case (lb_reg)
          4'h1: load_out.mac[7:0] <= rx_reg;
          4'h2: load_out.mac[15:8] <= rx_reg;
          4'h3: load_out.mac[23:16] <= rx_reg;
          4'h4: load_out.mac[31:24] <= rx_reg;
          4'h5: load_out.mac[39:32] <= rx_reg;
          4'h6: load_out.mac[47:40] <= rx_reg;
          LB_STRAP_FLAG: load_out.strap_valid <= (rx_reg == VALID_FLAG);
          4'h8: if (load_out.strap_valid) load_out.straps[7:0] <= rx_reg;
          4'h9: if (load_out.strap_valid) load_out.straps[15:8] <= rx_reg;
          4'ha: if (load_out.strap_valid) load_out.straps[23:16] <= rx_reg;
          LB_STRAP_LAST: if (load_out.strap_valid) load_out.straps[31:24] <= rx_reg;
          LB_BURST_FLAG: load_out.burst_valid <= (rx_reg == VALID_FLAG);
          LB_BURST_CNT: load_out.burst_cnt <= rx_reg;
          default: load_out.strap_valid <= load_out.strap_valid;
        endcase
        if ((lb_reg == LB_FLAG && rx_reg != VALID_FLAG) || lb_reg == LB_BURST_CNT
            || (soft_reg && lb_reg == LB_MAC_LAST)) begin
          load_done <= 1'b1;
          phy_sync <= !soft_reg;
          reg_wr_en <= !soft_reg;
          reg_wr_addr <= PHY_ACCESS_OFS;
        end
      end
    end
  end

  a_timeout_bound: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_WAIT && !do_sync_reg[1] && to_cnt_reg == 32'(TIMEOUT_CYCLES - 1))
    |=> nvm_response_timeout_flag) else $error("timeout flag not set");
  a_cs_idle_low: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_IDLE && $past(state_reg) == S_IDLE) |-> !eep_pins.cs)
    else $error("chip select high between commands");
  a_busy_when_active: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_SHIFT) |=> nvm_busy_flag) else $error("busy clear during command");
  a_ready_low_load: assert property (@(posedge ref_clk) disable iff (rst)
    loading_reg |=> !config_ready && !power_ready) else $error("ready high while loading");
  a_start_bit_one: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_SHIFT && bit_cnt_reg == 5'h00 && eep_pins.sk) |-> eep_pins.di)
    else $error("start bit not one");
  a_reg_wr_range: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr_en |-> (reg_wr_addr >= REG_MIN_OFS || reg_wr_addr == PHY_DATA_OFS
    || reg_wr_addr == PHY_ACCESS_OFS)) else $error("loader write out of range");
  a_bit_count: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_SHIFT) |-> (total_reg == 5'(HDR_BITS) + 5'(abits)
    || total_reg == 5'(HDR_BITS) + 5'(abits) + 5'(DATA_BITS))) else $error("frame length wrong");
  a_load_start: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_IDLE && start_load) |=> loading_reg && state_reg == S_LOAD)
    else $error("loader did not start");
  a_soft_no_strap: assert property (@(posedge ref_clk) disable iff (rst)
    (load_done && soft_reg) |-> !phy_sync) else $error("soft reset synced PHY");
endmodule
`default_nettype wire

// ===== sim/sel_eeprom_model.sv
/*
 Behavioural three-wire serial EEPROM facing sel_loader.
 Assumes pins come from the design's registered outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module sel_eeprom_model
  import sel_pkg::*;
#(
  parameter int BUSY_CYC = 150
) (
  input wire logic ref_clk,
  input wire sel_pins_t pins,
  input wire logic [1:0] size_strap,
  input wire logic stuck,
  output logic eep_do
);
  logic [7:0] mem [2048];
  logic [13:0] hdr;
  logic [7:0] dat, rd;
  logic [10:0] adr;
  logic [1:0] op;
  logic we_en = 1'b0;
  logic sk_q = 1'b0, cs_q = 1'b0, tgl = 1'b0, drv = 1'b0, val = 1'b0, pend = 1'b0, st;
  int ab, n = 0, nbits = 0, nfr = 0, bsy = 0, sk_err = 0;

  initial for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ 8'h96;
  // Released line toggles so a stale bit never passes for data
  assign eep_do = drv ? val : tgl;

  task automatic commit(input logic whole, input logic [7:0] v);
    if (we_en) begin
      if (whole) for (int i = 0; i < 2048; i++) mem[i] = v;
      else mem[adr] = v;
    end
    pend = 1'b1;
    bsy = we_en ? BUSY_CYC : 0;
  endtask

  always @(negedge ref_clk) begin
    ab = (size_strap == SIZE_7) ? 7 : (size_strap == SIZE_9) ? 9 : 11;
    tgl = ~tgl;
    if (bsy > 0) bsy = bsy - 1;
    if (pins.sk && !sk_q && !pins.cs) sk_err++;
    if (!pins.cs) begin
      if (cs_q && n > 0) begin
        nfr++;
        nbits = n;
      end
      n = 0;
      drv = 1'b0;
    end else if (pins.sk && !sk_q) begin
      n++;
      pend = 1'b0;
      if (n <= 3 + ab) hdr = {hdr[12:0], pins.di};
      else dat = {dat[6:0], pins.di};
      if (n == 3 + ab) begin
        st = hdr[ab + 2];
        op = 2'(hdr >> ab);
        adr = 11'(hdr) & 11'((1 << ab) - 1);
        rd = mem[adr];
        if (op == OP_ERASE) commit(1'b0, 8'hff);
        if (op == OP_EXT) begin
          case (adr[ab - 1 -: 2])
            EXT_WR_ENABLE: we_en = 1'b1;
            EXT_WR_DISABLE: we_en = 1'b0;
            EXT_BULK_ERASE: commit(1'b1, 8'hff);
            default: ;
          endcase
        end
      end
      if (n == 11 + ab && op == OP_WRITE) commit(1'b0, dat);
      if (n == 11 + ab && op == OP_EXT && adr[ab - 1 -: 2] == EXT_FILL_ALL) commit(1'b1, dat);
      if (n > 3 + ab && n <= 11 + ab && op == OP_READ) begin
        drv = 1'b1;
        val = rd[11 + ab - n];
      end
    end else if (n == 0 && pend) begin
      drv = 1'b1;
      val = bsy == 0 && !stuck;
    end
    sk_q = pins.sk;
    cs_q = pins.cs;
  end
endmodule
`default_nettype wire

// ===== sim/tb_sel_loader.sv
/*
 Self-checking bench for sel_loader with a behavioural EEPROM.
 Assumes a shortened timeout parameter and a 100 MHz ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_sel_loader;
  import sel_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, pin_reset_n = 1'b1;
  logic por_event = 1'b0, digital_reset = 1'b0, soft_reset = 1'b0;
  logic [1:0] size_strap = SIZE_7;
  logic cmd_go = 1'b0, data_wr = 1'b0, stuck = 1'b0;
  sel_cmd_t cmd_sel = SEL_CMD_READ;
  logic [10:0] cmd_location_field = 11'h000;
  logic [7:0] data_wdata = 8'h00;
  logic eep_do;
  sel_pins_t eep_pins;
  logic [7:0] nvm_data_reg;
  logic nvm_busy_flag, nvm_response_timeout_flag, config_ready, power_ready;
  sel_load_t load_out;
  logic load_done, phy_sync, reg_wr_en;
  logic [11:0] reg_wr_addr;
  int n_fail = 0, comparisons = 0, cyc = 0, n_sync = 0, n_done = 0, fr, sy, dn;

  sel_loader #(.TIMEOUT_CYCLES(200)) uut (.ref_clk, .rst, .pin_reset_n, .por_event,
    .digital_reset, .soft_reset, .size_strap, .cmd_go, .cmd_sel, .cmd_location_field,
    .data_wr, .data_wdata, .eep_do, .eep_pins, .nvm_data_reg, .nvm_busy_flag,
    .nvm_response_timeout_flag, .config_ready, .power_ready, .load_out, .load_done,
    .phy_sync, .reg_wr_en, .reg_wr_addr);
  sel_eeprom_model mdl (.ref_clk, .pins(eep_pins), .size_strap, .stuck, .eep_do);

  initial forever #5 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    chk(48'(got), 48'(exp));
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(negedge ref_clk);
    while (nvm_busy_flag !== 1'b0 && n < 40000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 40000) chk(1'b1, 1'b0);
  endtask

  task automatic cmd(input sel_cmd_t c, input logic [10:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    data_wr <= 1'b1;
    data_wdata <= d;
    @(posedge ref_clk);
    data_wr <= 1'b0;
    cmd_sel <= c;
    cmd_location_field <= a;
    cmd_go <= 1'b1;
    @(posedge ref_clk);
    cmd_go <= 1'b0;
    wait_idle();
  endtask

  task automatic load(input int k);
    fr = mdl.nfr;
    sy = n_sync;
    dn = n_done;
    @(posedge ref_clk);
    case (k)
      0: por_event <= 1'b1;
      1: digital_reset <= 1'b1;
      2: soft_reset <= 1'b1;
      3: pin_reset_n <= 1'b0;
      default: begin
        cmd_sel <= SEL_CMD_RELOAD;
        cmd_go <= 1'b1;
      end
    endcase
    repeat (k == 3 ? 4 : 1) @(posedge ref_clk);
    {por_event, digital_reset, soft_reset, cmd_go} <= 4'h0;
    pin_reset_n <= 1'b1;
    repeat (300) @(negedge ref_clk);
    chk({nvm_busy_flag, config_ready, power_ready}, 3'b100);
    wait_idle();
    fr = mdl.nfr - fr;
    sy = n_sync - sy;
    chk_n(n_done - dn, 1);
  endtask

  task automatic t_cmds();
    cmd(SEL_CMD_WRITE, 11'h055, 8'h3c);
    chk(mdl.mem[11'h055], 8'hc3);
    chk_n(mdl.nbits, 18);
    cmd(SEL_CMD_WR_ENABLE, 11'h000, 8'h00);
    chk_n(mdl.nbits, 10);
    chk(mdl.we_en, 1'b1);
    cmd(SEL_CMD_WRITE, 11'h055, 8'h3c);
    chk(mdl.mem[11'h055], 8'h3c);
    cmd(SEL_CMD_READ, 11'h07f, 8'h00);
    chk(nvm_data_reg, 8'he9);
    chk(mdl.st, 1'b1);
  endtask

  task automatic t_sizes();
    @(posedge ref_clk) size_strap <= SIZE_9;
    cmd(SEL_CMD_ERASE, 11'h1aa, 8'h00);
    chk(mdl.mem[11'h1aa], 8'hff);
    chk_n(mdl.nbits, 12);
    chk(mdl.mem[11'h0aa], 8'h3c);
    chk(nvm_response_timeout_flag, 1'b0);
    @(posedge ref_clk) size_strap <= SIZE_11;
    cmd(SEL_CMD_READ, 11'h5aa, 8'h00);
    chk(nvm_data_reg, 8'h3c);
    chk_n(mdl.nbits, 22);
    cmd(SEL_CMD_FILL_ALL, 11'h000, 8'h5a);
    chk({mdl.mem[0], mdl.mem[2047]}, 16'h5a5a);
    @(posedge ref_clk) size_strap <= 2'h3;
    cmd(SEL_CMD_BULK_ERASE, 11'h000, 8'h00);
    chk(mdl.mem[1024], 8'hff);
    chk_n(mdl.nbits, 14);
    cmd(SEL_CMD_WR_DISABLE, 11'h000, 8'h00);
    cmd(SEL_CMD_WRITE, 11'h010, 8'h77);
    chk(mdl.mem[16], 8'hff);
  endtask

  task automatic t_tmo();
    @(posedge ref_clk) stuck <= 1'b1;
    cmd(SEL_CMD_ERASE, 11'h020, 8'h00);
    chk(nvm_response_timeout_flag, 1'b1);
    @(posedge ref_clk) stuck <= 1'b0;
    cmd(SEL_CMD_WR_ENABLE, 11'h000, 8'h00);
    chk(nvm_response_timeout_flag, 1'b0);
  endtask

  task automatic t_load();
    logic [7:0] img [14] = '{8'ha5, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66,
      8'ha5, 8'h11, 8'h22, 8'h22, 8'h11, 8'ha5, 8'h03};
    for (int i = 0; i < 14; i++) mdl.mem[i] = img[i];
    @(posedge ref_clk) size_strap <= SIZE_7;
    load(0);
    chk(load_out.mac, 48'h665544332211);
    chk({load_out.straps, load_out.strap_valid, load_out.burst_valid}, {32'h11222211, 2'h3});
    chk(load_out.burst_cnt, 8'h03);
    chk_n(fr, 14);
    chk(config_ready, 1'b1);
    chk(reg_wr_addr, PHY_ACCESS_OFS);
    mdl.mem[7] = 8'h00;
    mdl.mem[8] = 8'h99;
    load(4);
    chk(load_out.strap_valid, 1'b0);
    chk(load_out.straps, 32'h11222211);
    chk_n(fr, 14);
    mdl.mem[1] = 8'h77;
    load(2);
    chk(load_out.mac[7:0], 8'h77);
    chk_n(fr, 7);
    mdl.mem[0] = 8'h00;
    load(3);
    chk_n(fr, 1);
    chk_n(sy, 1);
    load(1);
    chk_n(fr, 1);
    chk_n(mdl.sk_err, 0);
  endtask

  always @(negedge ref_clk) begin
    if (phy_sync === 1'b1) n_sync++;
    if (load_done === 1'b1) n_done++;
    if (reg_wr_en === 1'b1 && reg_wr_addr < REG_MIN_OFS && reg_wr_addr !== PHY_DATA_OFS
        && reg_wr_addr !== PHY_ACCESS_OFS) chk(reg_wr_addr, REG_MIN_OFS);
  end

  // Ceiling sits above the longest expected run of loads and commands
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 110000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({nvm_busy_flag, eep_pins.cs, config_ready}, 3'b100);
    @(posedge ref_clk) rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_cmds();
    t_sizes();
    t_tmo();
    t_load();
    print_verdict();
  end
endmodule
`default_nettype wire
